// [rtl/uic_consts.svh]
// Notes on behaviour
// - Clear bit 6 written one clears rx time-out interrupt; zero ignored.
// - Clear bit 5 written one clears transmit interrupt; zero ignored.
// - Clear bit 4 written one clears receive interrupt; zero ignored.
// - Clear register bits 3:0 are reserved, read zero, writes ignored.
// - Identification registers hold fixed read-only values, never changing.
// - One identifier byte sits in bits 7:0; bits 31:8 read zero.
// - Next word offset gives next identifier byte, lowest byte first.
//
// Constants for the UART interrupt clear and identification register bank.
// Assumes a 32-bit AHB-Lite slave decoding the low 12 address bits.
`ifndef UIC_CONSTS_SVH
`define UIC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define UIC_OFF_MASK   12'h038
`define UIC_OFF_RAW    12'h03C
`define UIC_OFF_MIS    12'h040
`define UIC_OFF_CLR    12'h044
`define UIC_OFF_IDU0   12'hFD0
`define UIC_OFF_IDU1   12'hFD4
`define UIC_OFF_IDU2   12'hFD8
`define UIC_OFF_IDU3   12'hFDC
`define UIC_OFF_IDL0   12'hFE0
`define UIC_OFF_IDL1   12'hFE4

// ----------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------
`define UIC_EVT_LSB    4
`define UIC_EVT_MSB    6
`define UIC_IDX_RX     0
`define UIC_IDX_TX     1
`define UIC_IDX_RT     2
`define UIC_ADDR_MSB   11
`define UIC_ID_MSB     7

// ----------------------------------------------------------------------
// Reset and fixed values (identification bytes are arbitrary)
// ----------------------------------------------------------------------
`define UIC_WORD_ZERO  32'h0000_0000
`define UIC_EVT_ZERO   3'h0
`define UIC_ID_U0      8'h5A // Arbitrary
`define UIC_ID_U1      8'h3C // Arbitrary
`define UIC_ID_U2      8'h21 // Arbitrary
`define UIC_ID_U3      8'h42 // Arbitrary
`define UIC_ID_L0      8'h6E // Arbitrary
`define UIC_ID_L1      8'h27 // Arbitrary

// ----------------------------------------------------------------------
// Bus encodings
// ----------------------------------------------------------------------
`define UIC_HSIZE_WORD 3'h2
`define UIC_HRESP_OKAY 1'h0

`endif

// [rtl/uic_pkg.sv]
// Types shared by the interrupt clear and identification register bank.
// Assumes the constants header is included by each design file.
package uic_pkg;

   typedef logic [31:0] uic_word_t;
   typedef logic [2:0]  uic_evt_t;
   typedef logic [11:0] uic_off_t;
   typedef logic [7:0]  uic_byte_t;

endpackage

// [rtl/uic_sticky.sv]
// One sticky interrupt status bit with set-over-clear priority.
// Assumes set and clear arrive as one-cycle pulses on the same clock.
`timescale 1ns/1ps
module uic_sticky
   import uic_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_b,
   // Event and software clear
   input  wire logic set,
   input  wire logic clr,
   // State
   output logic      q,
   output logic      q_next
);

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   // Set wins so an event in the clearing cycle is never lost
   always_comb begin
      q_next = set | (q & ~clr);
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         q <= 1'b0;
      end else begin
         q <= q_next;
      end
   end

endmodule

// [rtl/uic_regs.sv]
// Interrupt clear, status, mask and identification registers of a UART.
// Assumes a single AHB-Lite master; events are one-cycle pulses on clock.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "uic_consts.svh"
module uic_regs
   import uic_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Interrupt events from the UART datapath
   input  wire logic        rx_timeout_event,
   input  wire logic        tx_event,
   input  wire logic        rx_event,
   // Interrupt outputs
   output logic             irq,
   output logic [2:0]       irq_status
);

   // ----------------------------------------------------------------------
   // Address phase capture
   // ----------------------------------------------------------------------
   logic      acc;
   logic      acc_rd;
   uic_off_t  a_off;
   logic      dph_wr_reg;
   uic_off_t  dph_off_reg;

   assign acc    = hsel & hready & htrans[1];
   assign acc_rd = acc & ~hwrite;
   assign a_off  = haddr[`UIC_ADDR_MSB:0];

   // Only whole-word writes are honoured; narrower ones are dropped
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         dph_wr_reg <= 1'b0;
      end else if (hready) begin
         dph_wr_reg <= acc & hwrite & (hsize == `UIC_HSIZE_WORD);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         dph_off_reg <= '0;
      end else if (acc) begin
         dph_off_reg <= a_off;
      end
   end

   // ----------------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------------
   logic      wr_mask;
   logic      wr_clr;
   uic_evt_t  wr_evt;
   uic_evt_t  clr_vec;

   assign wr_mask = dph_wr_reg & (dph_off_reg == `UIC_OFF_MASK);
   assign wr_clr  = dph_wr_reg & (dph_off_reg == `UIC_OFF_CLR);
   assign wr_evt  = hwdata[`UIC_EVT_MSB:`UIC_EVT_LSB];

   // Zero bits and reserved bits 3:0 of a clear write have no effect
   assign clr_vec = wr_clr ? wr_evt : `UIC_EVT_ZERO;

   // ----------------------------------------------------------------------
   // Mask register
   // ----------------------------------------------------------------------
   uic_evt_t  mask_reg;
   uic_evt_t  mask_next;

   always_comb begin
      mask_next = mask_reg;
      if (wr_mask) begin
         mask_next = wr_evt;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         mask_reg <= `UIC_EVT_ZERO;
      end else begin
         mask_reg <= mask_next;
      end
   end

   // ----------------------------------------------------------------------
   // Sticky raw status
   // ----------------------------------------------------------------------
   uic_evt_t  evt_in;
   uic_evt_t  stat_q;
   uic_evt_t  stat_next;

   assign evt_in[`UIC_IDX_RX] = rx_event;
   assign evt_in[`UIC_IDX_TX] = tx_event;
   assign evt_in[`UIC_IDX_RT] = rx_timeout_event;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_stat
         uic_sticky u_bit (
            .clock  (clock),
            .rst_b  (rst_b),
            .set    (evt_in[gi]),
            .clr    (clr_vec[gi]),
            .q      (stat_q[gi]),
            .q_next (stat_next[gi])
         );
      end
   endgenerate

   assign irq_status = stat_q;

   // Clearing raw state also drops the masked view and the line
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat_next & mask_next);
      end
   end

   // ----------------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------------
   // Reads look at next-state values so a read right behind a write
   // already sees that write without a wait state.
   uic_word_t rd_val;

   always_comb begin
      rd_val = `UIC_WORD_ZERO;
      case (a_off)
         `UIC_OFF_MASK: begin
            rd_val[`UIC_EVT_MSB:`UIC_EVT_LSB] = mask_next;
         end
         `UIC_OFF_RAW: begin
            rd_val[`UIC_EVT_MSB:`UIC_EVT_LSB] = stat_next;
         end
         `UIC_OFF_MIS: begin
            rd_val[`UIC_EVT_MSB:`UIC_EVT_LSB] = stat_next & mask_next;
         end
         `UIC_OFF_CLR: begin
            rd_val = `UIC_WORD_ZERO;
         end
         // Upper 24 bits stay zero; bytes rise with the offset
         `UIC_OFF_IDU0: begin
            rd_val[`UIC_ID_MSB:0] = `UIC_ID_U0;
         end
         `UIC_OFF_IDU1: begin
            rd_val[`UIC_ID_MSB:0] = `UIC_ID_U1;
         end
         `UIC_OFF_IDU2: begin
            rd_val[`UIC_ID_MSB:0] = `UIC_ID_U2;
         end
         `UIC_OFF_IDU3: begin
            rd_val[`UIC_ID_MSB:0] = `UIC_ID_U3;
         end
         `UIC_OFF_IDL0: begin
            rd_val[`UIC_ID_MSB:0] = `UIC_ID_L0;
         end
         `UIC_OFF_IDL1: begin
            rd_val[`UIC_ID_MSB:0] = `UIC_ID_L1;
         end
         default: begin
            rd_val = `UIC_WORD_ZERO;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Bus answer
   // ----------------------------------------------------------------------
   // Identification bytes are constants, so writes there fall away
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         hrdata <= `UIC_WORD_ZERO;
      end else if (acc_rd) begin
         hrdata <= rd_val;
      end else if (acc) begin
         hrdata <= `UIC_WORD_ZERO;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         hreadyout <= 1'b1;
         hresp     <= `UIC_HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= `UIC_HRESP_OKAY;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   logic clr_wr_ok;
   assign clr_wr_ok = wr_clr;

   a_clr_rt_bit: assert property (
      clr_wr_ok && hwdata[`UIC_EVT_LSB + `UIC_IDX_RT] && !rx_timeout_event
      |=> !irq_status[`UIC_IDX_RT]
          && !(irq_status[`UIC_IDX_RT] & mask_reg[`UIC_IDX_RT])
   ) else $error("rx timeout status not cleared by write of one");

   a_clr_rt_zero: assert property (
      clr_wr_ok && !hwdata[`UIC_EVT_LSB + `UIC_IDX_RT]
      && irq_status[`UIC_IDX_RT]
      |=> irq_status[`UIC_IDX_RT]
   ) else $error("rx timeout status lost on write of zero");

   a_clr_tx_bit: assert property (
      clr_wr_ok && !tx_event
      |=> irq_status[`UIC_IDX_TX] ==
          ($past(irq_status[`UIC_IDX_TX])
           & ~$past(hwdata[`UIC_EVT_LSB + `UIC_IDX_TX]))
   ) else $error("tx status wrong after clear write");

   a_clr_rx_bit: assert property (
      clr_wr_ok && !rx_event
      |=> irq_status[`UIC_IDX_RX] ==
          ($past(irq_status[`UIC_IDX_RX])
           & ~$past(hwdata[`UIC_EVT_LSB + `UIC_IDX_RX]))
   ) else $error("rx status wrong after clear write");

   a_low_bits_dead: assert property (
      clr_wr_ok && (hwdata[`UIC_EVT_MSB:`UIC_EVT_LSB] == `UIC_EVT_ZERO)
      |=> $stable(irq_status) || ($past(evt_in) != `UIC_EVT_ZERO)
   ) else $error("reserved clear bits changed status");

   a_clr_reads_zero: assert property (
      acc_rd && (a_off == `UIC_OFF_CLR) |=> hrdata == `UIC_WORD_ZERO
   ) else $error("clear register read not zero");

   a_id_lower_first: assert property (
      acc_rd && (a_off == `UIC_OFF_IDL0)
      |=> hrdata == {24'h00_0000, `UIC_ID_L0}
   ) else $error("lowest identifier byte wrong");

   a_id_byte_order: assert property (
      acc_rd && (a_off == `UIC_OFF_IDU1)
      |=> hrdata[`UIC_ID_MSB:0] == `UIC_ID_U1 && hrdata[31:8] == 24'h00_0000
   ) else $error("identifier byte order wrong");

   a_id_fixed_value: assert property (
      acc_rd && (a_off == `UIC_OFF_IDU0)
      |=> hrdata == {24'h00_0000, `UIC_ID_U0}
   ) else $error("identifier value changed");

   a_set_wins_clr: assert property (
      tx_event && clr_vec[`UIC_IDX_TX] |=> irq_status[`UIC_IDX_TX]
   ) else $error("event lost against clear");

   a_irq_tracks: assert property (
      irq == |(irq_status & mask_reg)
   ) else $error("interrupt line disagrees with status and mask");

   a_bus_okay: assert property (
      hreadyout && hresp == `UIC_HRESP_OKAY
   ) else $error("slave not ready or not okay");

   // Identification, bus-side and full-clear checks
   a_id_upper_order: assert property (
      acc_rd && (a_off == `UIC_OFF_IDU2)
      |=> hrdata == {24'h00_0000, `UIC_ID_U2}
   ) else $error("upper identifier byte order wrong");

   a_id_high_zero: assert property (
      acc_rd && (a_off >= `UIC_OFF_IDU0)
      |=> hrdata[31:8] == 24'h00_0000
   ) else $error("identifier upper bits not zero");

   a_id_write_dead: assert property (
      dph_wr_reg && (dph_off_reg >= `UIC_OFF_IDU0)
      |=> $stable(mask_reg)
          && (($past(irq_status) & ~irq_status) == `UIC_EVT_ZERO)
   ) else $error("identification write changed state");

   a_narrow_dropped: assert property (
      acc && hwrite && (hsize != `UIC_HSIZE_WORD) |=> !dph_wr_reg
   ) else $error("narrow write not dropped");

   a_full_clr_irq: assert property (
      clr_wr_ok && (hwdata[`UIC_EVT_MSB:`UIC_EVT_LSB] == ~`UIC_EVT_ZERO)
      && (evt_in == `UIC_EVT_ZERO) |=> !irq
   ) else $error("interrupt line not dropped by full clear");

   c_clear_write: cover property (clr_wr_ok && (irq_status != `UIC_EVT_ZERO));
   c_id_read:     cover property (acc_rd && (a_off == `UIC_OFF_IDL1));
   c_irq_rise:    cover property (!irq ##1 irq);
   c_set_clash:   cover property (rx_event && clr_vec[`UIC_IDX_RX]);

endmodule

// [dv/tb_uart_irq_clear_and_id_regs.sv]
// Self-checking bench for the interrupt clear and identification bank.
// Assumes the bank is the only slave of a single-master AHB-Lite bus.
`timescale 1ns/1ps
`include "uic_consts.svh"
module tb_uart_irq_clear_and_id_regs
   import uic_pkg::*;
;
   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic        clock;
   logic        rst_b;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic        rx_timeout_event;
   logic        tx_event;
   logic        rx_event;
   logic        irq;
   logic [2:0]  irq_status;
   int          n_errors;
   int          samples_checked;
   uic_off_t    id_off [6] = '{`UIC_OFF_IDU0, `UIC_OFF_IDU1, `UIC_OFF_IDU2,
                               `UIC_OFF_IDU3, `UIC_OFF_IDL0, `UIC_OFF_IDL1};
   uic_byte_t   id_val [6] = '{`UIC_ID_U0, `UIC_ID_U1, `UIC_ID_U2,
                               `UIC_ID_U3, `UIC_ID_L0, `UIC_ID_L1};

   assign hready = hreadyout;

   uic_regs u_uic_regs (
      .clock            (clock),
      .rst_b            (rst_b),
      .hsel             (hsel),
      .haddr            (haddr),
      .htrans           (htrans),
      .hwrite           (hwrite),
      .hsize            (hsize),
      .hwdata           (hwdata),
      .hready           (hready),
      .hreadyout        (hreadyout),
      .hrdata           (hrdata),
      .hresp            (hresp),
      .rx_timeout_event (rx_timeout_event),
      .tx_event         (tx_event),
      .rx_event         (rx_event),
      .irq              (irq),
      .irq_status       (irq_status)
   );

   always #2.5 clock = ~clock;

   // ------------------------------------------------------------------
   // Bus and check helpers
   // ------------------------------------------------------------------
   task automatic chk(input string what, input uic_word_t exp,
                      input uic_word_t got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // Bounded so a stuck ready shows up as a mismatch, not a hang
   task automatic wait_ready();
      int guard;
      guard = 0;
      @(posedge clock);
      while (hready !== 1'b1 && guard < 50) begin
         guard++;
         @(posedge clock);
      end
      if (guard >= 50) chk("hready", 32'h0000_0001, 32'h0000_0000);
   endtask

   task automatic bus_write(input uic_off_t off, input uic_word_t d);
      hsel   <= 1'b1;
      haddr  <= {20'h0_0000, off};
      htrans <= 2'b10;
      hwrite <= 1'b1;
      hsize  <= `UIC_HSIZE_WORD;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready();
   endtask

   task automatic bus_read(input uic_off_t off, output uic_word_t d);
      hsel   <= 1'b1;
      haddr  <= {20'h0_0000, off};
      htrans <= 2'b10;
      hwrite <= 1'b0;
      hsize  <= `UIC_HSIZE_WORD;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      wait_ready();
      d = hrdata;
      chk("hresp", `UIC_HRESP_OKAY, {31'h0, hresp});
   endtask

   // Write of a chosen size, events pulsed during its data phase
   task automatic write_with(input uic_off_t off, input uic_word_t d,
                             input logic [2:0] sz, input uic_evt_t e);
      hsel   <= 1'b1;
      haddr  <= {20'h0_0000, off};
      htrans <= 2'b10;
      hwrite <= 1'b1;
      hsize  <= sz;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hsize  <= `UIC_HSIZE_WORD;
      hwdata <= d;
      {rx_timeout_event, tx_event, rx_event} <= e;
      wait_ready();
      {rx_timeout_event, tx_event, rx_event} <= 3'h0;
   endtask

   // Events are one-cycle pulses, order {rt, tx, rx}
   task automatic pulse(input uic_evt_t e);
      {rx_timeout_event, tx_event, rx_event} <= e;
      @(posedge clock);
      {rx_timeout_event, tx_event, rx_event} <= 3'h0;
      @(posedge clock);
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic test_reset();
      uic_word_t d;
      chk("irq", 32'h0000_0000, {31'h0, irq});
      chk("status", 32'h0000_0000, {29'h0, irq_status});
      bus_read(`UIC_OFF_MASK, d);
      chk("mask", `UIC_WORD_ZERO, d);
      bus_read(`UIC_OFF_CLR, d);
      chk("clear read", `UIC_WORD_ZERO, d);
   endtask

   task automatic test_ids();
      uic_word_t d;
      for (int i = 0; i < 6; i++) begin
         bus_read(id_off[i], d);
         chk("ident", {24'h00_0000, id_val[i]}, d);
         bus_write(id_off[i], 32'hFFFF_FFFF);
         bus_read(id_off[i], d);
         chk("ident after write", {24'h00_0000, id_val[i]}, d);
      end
   endtask

   task automatic test_clear();
      uic_word_t d;
      uic_word_t exp;
      bus_write(`UIC_OFF_MASK, 32'h0000_0070);
      for (int i = 0; i < 3; i++) begin
         pulse(3'h7);
         chk("status set", 32'h0000_0007, {29'h0, irq_status});
         // Zeros on 6:4 and ones on reserved bits must change nothing
         bus_write(`UIC_OFF_CLR, 32'h0000_000F);
         @(posedge clock);
         chk("status kept", 32'h0000_0007, {29'h0, irq_status});
         bus_write(`UIC_OFF_CLR, 32'h0000_0010 << i);
         @(posedge clock);
         exp = 32'h0000_0007 & ~(32'h0000_0001 << i);
         chk("status one", exp, {29'h0, irq_status});
         chk("irq left", 32'h0000_0001, {31'h0, irq});
         bus_read(`UIC_OFF_CLR, d);
         chk("clear read", `UIC_WORD_ZERO, d);
      end
      bus_write(`UIC_OFF_CLR, 32'h0000_0070);
      @(posedge clock);
      chk("status all", 32'h0000_0000, {29'h0, irq_status});
      chk("irq all", 32'h0000_0000, {31'h0, irq});
   endtask

   task automatic test_mask();
      uic_word_t d;
      bus_write(`UIC_OFF_MASK, 32'h0000_0020);
      pulse(3'h1);
      chk("irq masked", 32'h0000_0000, {31'h0, irq});
      bus_read(`UIC_OFF_MIS, d);
      chk("masked status", 32'h0000_0000, d);
      pulse(3'h2);
      chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
      bus_read(`UIC_OFF_MIS, d);
      chk("masked status", 32'h0000_0020, d);
      bus_read(`UIC_OFF_RAW, d);
      chk("raw status", 32'h0000_0030, d);
      bus_write(`UIC_OFF_CLR, 32'h0000_0020);
      @(posedge clock);
      chk("irq cleared", 32'h0000_0000, {31'h0, irq});
      chk("rx kept", 32'h0000_0001, {29'h0, irq_status});
      bus_read(12'h100, d);
      chk("unmapped", `UIC_WORD_ZERO, d);
   endtask

   task automatic test_corners();
      uic_word_t d;
      // An event in the clearing data phase must survive the clear
      write_with(`UIC_OFF_CLR, 32'h0000_0070, `UIC_HSIZE_WORD, 3'h7);
      @(posedge clock);
      chk("status clash", 32'h0000_0007, {29'h0, irq_status});
      chk("irq clash", 32'h0000_0001, {31'h0, irq});
      // Byte-sized writes must leave the mask alone
      write_with(`UIC_OFF_MASK, 32'h0000_0070, 3'h0, 3'h0);
      bus_read(`UIC_OFF_MASK, d);
      chk("mask narrow", 32'h0000_0020, d);
      // Read-modify-write keeps the reserved bits as read
      d = d | 32'h0000_0040;
      bus_write(`UIC_OFF_MASK, d);
      bus_read(`UIC_OFF_MASK, d);
      chk("mask rmw", 32'h0000_0060, d);
      // Reset in mid-run with status and mask set
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      chk("status reset", 32'h0000_0000, {29'h0, irq_status});
      chk("irq reset", 32'h0000_0000, {31'h0, irq});
      chk("hrdata reset", `UIC_WORD_ZERO, hrdata);
      bus_read(`UIC_OFF_MASK, d);
      chk("mask reset", `UIC_WORD_ZERO, d);
   endtask

   // ------------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------------
   task automatic tally_and_finish();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      #20000;
      n_errors++;
      tally_and_finish();
   end

   initial begin
      clock = 1'b0;
      rst_b = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = `UIC_HSIZE_WORD;
      hwdata = 32'h0000_0000;
      {rx_timeout_event, tx_event, rx_event} = 3'h0;
      n_errors = 0;
      samples_checked = 0;
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      test_reset();
      test_ids();
      test_clear();
      test_mask();
      test_corners();
      tally_and_finish();
   end
endmodule
